// ---- opsm_pkg.sv ----
// shared constants of the output port block: register indices, reset
// values, clock figures and divider taps.
// assumes a 32-bit apb slave; register byte address is four times its index.
package opsm_pkg;

   // ---------------------------------------------------------------
   // register indices and address decode
   // ---------------------------------------------------------------
   localparam logic [11:0] IDX_GROUP_A = 12'hf50;
   localparam logic [11:0] IDX_GROUP_B = 12'hf51;
   localparam logic [11:0] IDX_GROUP_C = 12'hf52;
   localparam logic [11:0] IDX_GROUP_D = 12'hf53;
   localparam logic [11:0] IDX_GROUP_E = 12'hf54;
   localparam logic [11:0] IDX_TIMER   = 12'hf79;
   localparam logic [11:0] IDX_HIZ     = 12'hf7b;
   localparam int          ADDR_W      = 14;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int          TMR_ROUTE_BIT = 3;
   localparam int          TMR_SEL_LSB   = 0;
   localparam logic [3:0]  GROUP_E_RST   = 4'hf;
   localparam logic [3:0]  DATA_RST      = 4'h0;
   localparam logic [3:0]  HIZ_RST       = 4'h0;
   localparam logic [3:0]  TIMER_RST     = 4'h0;
   localparam logic [3:0]  HIZ_REDUCED   = 4'hc;

   // ---------------------------------------------------------------
   // timing figures and slow clock divider taps
   // ---------------------------------------------------------------
   localparam int          SYS_CLK_HZ    = 20000000;
   localparam int          SLOW_OSC_HZ   = 32768;
   localparam int          DIV_W         = 12;
   localparam int          LINE16_HZ     = 1024;
   localparam int          LINE8_HZ      = 512;
   localparam int          FRAME_HZ      = 32;
   // tap k of the ripple counter runs at slow_osc / 2^(k+1)
   localparam int          LINE16_TAP    = 4;
   localparam int          LINE8_TAP     = 5;
   // line edges per half frame period
   localparam logic [4:0]  LINES_16      = 5'h10;
   localparam logic [4:0]  LINES_8       = 5'h08;

endpackage : opsm_pkg

// ---- opsm_output_port.sv ----
// output port block: five 4-bit output groups with build-time special
// functions, data registers, tri-state control and timer tick routing.
// assumes an apb master on clk; slow_osc and fast_osc arrive as pins and
// are synchronised; memory sequencer and serial unit run on clk.
//
// The implementer's own choice: the APB slave port.

module opsm_output_port #(
   parameter bit       FULL_CFG      = 1'b1,
   parameter bit       EXT_MEM       = 1'b0,
   parameter bit       A13_ON_D1     = 1'b1,
   parameter bit       BUZZ_EN       = 1'b0,
   parameter bit       BUZZ_INV_EN   = 1'b0,
   parameter int       BUZZ_TAP      = 3,
   parameter bit       CLK_OUT_EN    = 1'b0,
   parameter bit       CLK_INV_EN    = 1'b0,
   parameter bit       CLK_FAST_SRC  = 1'b0,
   parameter int       CLK_DIV_LOG   = 0,
   parameter bit       LCD_EN        = 1'b0,
   parameter bit       LCD_DUTY16    = 1'b1,
   parameter bit       D3_SERIAL     = 1'b0,
   parameter bit       D3_TWO_STATE  = 1'b0
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [opsm_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                  pwdata,
   input  wire logic [3:0]                   pstrb,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // oscillator pins
   input  wire logic                         slow_osc,
   input  wire logic                         fast_osc,
   // neighbouring units on clk
   input  wire logic [13:0]                  ext_addr,
   input  wire logic                         store_strobe_n,
   input  wire logic                         load_strobe_n,
   input  wire logic                         serial_ready,
   // output pins
   output logic      [3:0]                   out_group_a,
   output logic      [3:0]                   out_group_b,
   output logic      [3:0]                   out_group_c,
   output logic      [3:0]                   out_group_d,
   output logic      [3:0]                   out_group_e,
   output logic                              oe_group_a,
   output logic                              oe_group_b,
   output logic                              oe_group_c,
   output logic                              oe_group_d
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   // build choices are fixed here and never change at run time; a pairing
   // that would give one pin two sources stops elaboration instead of
   // leaving a silent priority between them
   if (BUZZ_INV_EN && !BUZZ_EN)
   begin : g_chk_buzz_pair
      $error("inverted buzzer needs the buzzer on the neighbouring pin");
   end
   if (BUZZ_INV_EN && CLK_OUT_EN)
   begin : g_chk_e2_source
      $error("e2 cannot carry both inverted buzzer and clock");
   end
   if (CLK_INV_EN && LCD_EN)
   begin : g_chk_e0_source
      $error("e0 cannot carry both inverted clock and line sync");
   end
   if (CLK_INV_EN && !CLK_OUT_EN)
   begin : g_chk_clk_pair
      $error("inverted clock needs the clock on e2");
   end
   if (CLK_DIV_LOG < 0 || CLK_DIV_LOG > 7)
   begin : g_chk_clk_div
      $error("clock divisor must be 1 to 128");
   end
   if (BUZZ_TAP < 0 || BUZZ_TAP > 7)
   begin : g_chk_buzz_tap
      $error("buzzer tap out of range");
   end
   if (EXT_MEM && !FULL_CFG)
   begin : g_chk_ext_mem
      $error("external memory needs the full build");
   end

   // ---------------------------------------------------------------
   // oscillator synchronisers and slow divider
   // ---------------------------------------------------------------
   logic                                     slow_meta;
   logic                                     slow_sync;
   logic                                     slow_prev;
   logic                                     fast_meta;
   logic                                     fast_sync;
   logic [opsm_pkg::DIV_W-1:0]               div_cnt;
   logic                                     slow_tick;

   // two flops before use; fast_osc is only usable when well below clk
   always_ff @(posedge clk)
   begin
      slow_meta <= slow_osc;
      slow_sync <= slow_meta;
      slow_prev <= slow_sync;
      fast_meta <= fast_osc;
      fast_sync <= fast_meta;
   end

   assign slow_tick = slow_sync & ~slow_prev;

   // free-running ripple counter on slow_osc rising edges
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         div_cnt <= '0;
      else if (slow_tick)
         div_cnt <= div_cnt + 1'b1;
   end

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [3:0]                               data_a;
   logic [3:0]                               data_b;
   logic [3:0]                               data_c;
   logic [2:0]                               data_d_low;
   logic                                     data_d3;
   logic [3:0]                               data_e;
   logic [3:0]                               timer_ctl;
   logic [3:0]                               hiz_ctl;

   wire  [11:0] reg_idx   = paddr[opsm_pkg::ADDR_W-1:2];
   wire         hit_a     = FULL_CFG && reg_idx == opsm_pkg::IDX_GROUP_A;
   wire         hit_b     = FULL_CFG && reg_idx == opsm_pkg::IDX_GROUP_B;
   wire         hit_c     = reg_idx == opsm_pkg::IDX_GROUP_C;
   wire         hit_d     = reg_idx == opsm_pkg::IDX_GROUP_D;
   wire         hit_e     = reg_idx == opsm_pkg::IDX_GROUP_E;
   wire         hit_tmr   = reg_idx == opsm_pkg::IDX_TIMER;
   wire         hit_hiz   = reg_idx == opsm_pkg::IDX_HIZ;
   wire         hit_any   = hit_a | hit_b | hit_c | hit_d | hit_e | hit_tmr
                            | hit_hiz;
   wire         aligned   = paddr[1:0] == 2'b00;
   wire         access    = psel & penable;
   wire         wr_en     = access & pwrite & hit_any & aligned & pstrb[0];
   wire  [3:0]  wr_nib    = pwdata[3:0];
   // reduced build drops the a and b tri-state bits
   wire  [3:0]  hiz_mask  = FULL_CFG ? 4'hf : opsm_pkg::HIZ_REDUCED;
   wire  [3:0]  rd_nib    = hit_a   ? data_a :
                            hit_b   ? data_b :
                            hit_c   ? data_c :
                            hit_d   ? {data_d3, data_d_low} :
                            hit_e   ? data_e :
                            hit_tmr ? timer_ctl :
                            hit_hiz ? hiz_ctl & hiz_mask : 4'h0;

   // zero wait states; unmapped or misaligned addresses answer with error
   // so software sees a refused access instead of a silent drop
   assign pready  = 1'b1;
   assign pslverr = access & ~(hit_any & aligned);

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         prdata <= '0;
      else if (psel & ~penable)
         prdata <= {28'h0000000, (hit_any & aligned) ? rd_nib : 4'h0};
   end

   // data registers of groups a to d
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         data_a     <= opsm_pkg::DATA_RST;
         data_b     <= opsm_pkg::DATA_RST;
         data_c     <= opsm_pkg::DATA_RST;
         data_d_low <= opsm_pkg::DATA_RST[2:0];
      end
      else if (wr_en)
      begin
         if (hit_a)
            data_a <= wr_nib;
         if (hit_b)
            data_b <= wr_nib;
         if (hit_c)
            data_c <= wr_nib;
         if (hit_d)
            data_d_low <= wr_nib[2:0];
      end
   end

   // d3 skips reset when built two-state in plain or tick mode
   generate
      if (D3_TWO_STATE && !D3_SERIAL)
      begin : g_d3_noreset
         always_ff @(posedge clk)
         begin
            if (wr_en && hit_d)
               data_d3 <= wr_nib[3];
         end
      end
      else
      begin : g_d3_reset
         always_ff @(posedge clk)
         begin
            if (sys_rst)
               data_d3 <= opsm_pkg::DATA_RST[3];
            else if (wr_en && hit_d)
               data_d3 <= wr_nib[3];
         end
      end
   endgenerate

   // group e data doubles as gate bits, so it wakes up all ones
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         data_e <= opsm_pkg::GROUP_E_RST;
      else if (wr_en && hit_e)
         data_e <= wr_nib;
   end

   // tick routing and divider select, tri-state control
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         timer_ctl <= opsm_pkg::TIMER_RST;
         hiz_ctl   <= opsm_pkg::HIZ_RST;
      end
      else if (wr_en)
      begin
         if (hit_tmr)
            timer_ctl <= wr_nib;
         if (hit_hiz)
            hiz_ctl <= wr_nib & hiz_mask;
      end
   end

   // ---------------------------------------------------------------
   // special function sources
   // ---------------------------------------------------------------
   logic                                     line_prev;
   logic [4:0]                               line_cnt;
   logic                                     phase_tgl;

   wire        route_en  = timer_ctl[opsm_pkg::TMR_ROUTE_BIT];
   wire  [2:0] tick_sel  = timer_ctl[opsm_pkg::TMR_SEL_LSB +: 3];
   wire        tick_sig  = div_cnt[tick_sel];
   wire        buzz_sig  = div_cnt[BUZZ_TAP];
   wire        slow_div  = (CLK_DIV_LOG == 0) ? slow_sync
                           : div_cnt[(CLK_DIV_LOG == 0) ? 0 : CLK_DIV_LOG - 1];
   wire        clk_sig   = CLK_FAST_SRC ? fast_sync : slow_div;
   wire        line_sig  = LCD_DUTY16 ? div_cnt[opsm_pkg::LINE16_TAP]
                           : div_cnt[opsm_pkg::LINE8_TAP];
   wire        line_rise = line_sig & ~line_prev;
   wire  [4:0] line_last = LCD_DUTY16 ? opsm_pkg::LINES_16 : opsm_pkg::LINES_8;
   // flip decided now and shown at the pin on the same edge that lifts
   // line sync, so the frame pin never lags the line edge by a clock
   wire        phase_flip = line_rise & (line_cnt == line_last);

   // phase toggle flips every 16 or 8 line edges, giving 32 Hz
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         line_prev <= 1'b0;
         line_cnt  <= 5'h01;
         phase_tgl <= 1'b0;
      end
      else
      begin
         line_prev <= line_sig;
         if (line_rise)
         begin
            line_cnt <= (line_cnt == line_last) ? 5'h01 : line_cnt + 5'h01;
            if (phase_flip)
               phase_tgl <= ~phase_tgl;
         end
      end
   end

   // ---------------------------------------------------------------
   // pin function selection
   // ---------------------------------------------------------------
   // buzzer gate: 0 lets the tone through, 1 forces both pins low
   wire        buzz_on   = ~data_e[3] & buzz_sig;
   wire        buzz_inv  = ~data_e[3] & ~buzz_sig;
   wire        tick_pin  = route_en ? (data_d3 | tick_sig) : data_d3;
   wire        d3_pin    = D3_SERIAL ? serial_ready : tick_pin;
   wire        a13_pin   = A13_ON_D1 ? ext_addr[13] : store_strobe_n;

   wire  [3:0] next_a    = EXT_MEM ? ext_addr[3:0] : data_a;
   wire  [3:0] next_b    = EXT_MEM ? ext_addr[7:4] : data_b;
   wire  [3:0] next_c    = EXT_MEM ? ext_addr[11:8] : data_c;
   wire  [3:0] next_d    = EXT_MEM ? {d3_pin, load_strobe_n, a13_pin, ext_addr[12]}
                           : {d3_pin, data_d_low};
   // e2 register is not looked at when the pin carries the inverse tone
   wire        next_e3   = BUZZ_EN ? buzz_on : data_e[3];
   wire        next_e2   = BUZZ_INV_EN ? buzz_inv
                           : CLK_OUT_EN ? (data_e[2] | clk_sig) : data_e[2];
   wire        next_e1   = LCD_EN ? (data_e[1] | (phase_tgl ^ phase_flip)) : data_e[1];
   wire        next_e0   = CLK_INV_EN ? (data_e[0] | ~clk_sig)
                           : LCD_EN ? (data_e[0] | line_sig) : data_e[0];
   wire  [3:0] next_e    = {next_e3, next_e2, next_e1, next_e0};

   // two-state d3 ignores its tri-state bit
   wire        next_oe_d = hiz_ctl[3] | D3_TWO_STATE | D3_SERIAL;

   // ---------------------------------------------------------------
   // pin registers
   // ---------------------------------------------------------------
   // registering the pins removes glitches when a gate bit changes,
   // at the cost of one clock of latency from every source
   always_ff @(posedge clk)
   begin
      out_group_a <= FULL_CFG ? next_a : 4'h0;
      out_group_b <= FULL_CFG ? next_b : 4'h0;
      out_group_c <= next_c;
      out_group_d <= next_d;
      out_group_e <= next_e;
   end

   // whole-group enables; reset floats every group except d, which a two-state or serial d3 build drives
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         oe_group_a <= 1'b0;
         oe_group_b <= 1'b0;
         oe_group_c <= 1'b0;
         oe_group_d <= D3_TWO_STATE | D3_SERIAL;
      end
      else
      begin
         oe_group_a <= hiz_ctl[0] & FULL_CFG;
         oe_group_b <= hiz_ctl[1] & FULL_CFG;
         oe_group_c <= hiz_ctl[2];
         oe_group_d <= next_oe_d;
      end
   end

endmodule : opsm_output_port

// ---- opsm_far_side.sv ----
// far side of the port block: oscillator pins, memory sequencer, serial unit.
// assumes the bench clock; slow_osc is scaled to 16 clk periods.
module opsm_far_side (
   // bench clock
   input  wire logic        clk,
   // oscillator pins
   output logic             slow_osc,
   output logic             fast_osc,
   // memory sequencer and serial unit
   output logic [13:0]      ext_addr,
   output logic             store_strobe_n,
   output logic             load_strobe_n,
   output logic             serial_ready
);
   timeunit 1ns;
   timeprecision 1ns;

   // free-running oscillators; scaled down so frame-rate checks stay short
   initial
   begin
      slow_osc = 1'b0;
      fast_osc = 1'b0;
      ext_addr = 14'h0;
      store_strobe_n = 1'b1;
      load_strobe_n = 1'b1;
      serial_ready = 1'b0;
   end
   always #400 slow_osc = ~slow_osc;
   always #130 fast_osc = ~fast_osc;

   // sources keep moving so a leak onto a dc pin cannot hide
   always @(posedge clk)
   begin
      ext_addr <= ext_addr + 14'h1;
      store_strobe_n <= ~store_strobe_n;
      load_strobe_n <= ext_addr[1];
      serial_ready <= ext_addr[2];
   end
endmodule : opsm_far_side

// ---- opsm_output_port_checker.sv ----
// assertions on the pins and apb port of the output port block.
// assumes the bench build: buzzer pair on e3/e2, lcd sync on e1/e0.
module opsm_output_port_checker (
   // clock and reset
   input wire logic                        clk,
   input wire logic                        sys_rst,
   // apb
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [opsm_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic [3:0]                  pstrb,
   input wire logic [31:0]                 prdata,
   // pins
   input wire logic [3:0]                  out_group_c,
   input wire logic [3:0]                  out_group_e,
   input wire logic                        oe_group_a,
   input wire logic                        oe_group_b,
   input wire logic                        oe_group_c,
   input wire logic                        oe_group_d
);
   // writes that land in a register
   wire logic       acc    = psel && penable && pwrite && pstrb[0];
   wire logic       wr_c   = acc && paddr == {opsm_pkg::IDX_GROUP_C, 2'b00};
   wire logic       wr_e   = acc && paddr == {opsm_pkg::IDX_GROUP_E, 2'b00};
   wire logic       wr_hiz = acc && paddr == {opsm_pkg::IDX_HIZ, 2'b00};
   wire logic [3:0] oe_all = {oe_group_d, oe_group_c, oe_group_b, oe_group_a};
   logic      [2:0] quiet;

   // cycles since last select; pin moves caused by writes are excluded
   always_ff @(posedge clk)
   begin
      if (sys_rst || psel)
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_hiz_reset: assert property ($fell(sys_rst) |-> oe_all == 4'h0)
      else $error("group enables not clear after reset");
   a_e_reset: assert property ($fell(sys_rst) |-> out_group_e == 4'h3)
      else $error("group e pins wrong after reset");
   a_buzz_opposed: assert property (out_group_e[3] |-> !out_group_e[2])
      else $error("buzzer pins high together");
   a_buzz_gated: assert property (wr_e && pwdata[3] |-> ##2 out_group_e[3:2] == 2'b00)
      else $error("buzzer pins not low with gate set");
   a_pin_follows: assert property (wr_c |-> ##2 out_group_c == $past(pwdata[3:0], 2))
      else $error("group c pins do not follow data");
   a_hiz_groups: assert property (wr_hiz |-> ##2 oe_all == $past(pwdata[3:0], 2))
      else $error("group enables do not follow control");
   a_phase_sync: assert property (quiet > 3'h4 && $changed(out_group_e[1])
      |-> $rose(out_group_e[0]))
      else $error("phase toggle moved off a line edge");
   a_read_nibble: assert property (prdata[31:4] == 28'h0)
      else $error("read data above bit 3 not zero");
endmodule : opsm_output_port_checker

bind opsm_output_port opsm_output_port_checker u_chk (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .out_group_c(out_group_c), .out_group_e(out_group_e),
   .oe_group_a(oe_group_a), .oe_group_b(oe_group_b),
   .oe_group_c(oe_group_c), .oe_group_d(oe_group_d)
);

// ---- tb_output_port_special_mux.sv ----
// bench for the output port block: apb tasks, pin edge counters, scenarios.
// assumes the far-side model and the checker bind are compiled first.
module tb_output_port_special_mux;
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [13:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h1;
   logic [31:0] prdata;
   logic        pready, pslverr, slow_osc, fast_osc, st_n, ld_n, ser_rdy;
   logic [13:0] ext_addr;
   logic [3:0]  out_a, out_b, out_c, out_d, out_e, oe;
   logic [15:0] mem_pins;
   int          n_mismatch = 0;
   int          checked = 0;
   wire  [7:0]  pins = {out_e, out_d};

   // bench clock, 50 ns period
   always #25 clk = ~clk;

   opsm_far_side far (.clk(clk), .slow_osc(slow_osc), .fast_osc(fast_osc),
      .ext_addr(ext_addr), .store_strobe_n(st_n), .load_strobe_n(ld_n),
      .serial_ready(ser_rdy));

   opsm_output_port #(.BUZZ_EN(1'b1), .BUZZ_INV_EN(1'b1), .LCD_EN(1'b1)) dut (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slow_osc(slow_osc), .fast_osc(fast_osc), .ext_addr(ext_addr),
      .store_strobe_n(st_n), .load_strobe_n(ld_n), .serial_ready(ser_rdy),
      .out_group_a(out_a), .out_group_b(out_b), .out_group_c(out_c),
      .out_group_d(out_d), .out_group_e(out_e), .oe_group_a(oe[0]),
      .oe_group_b(oe[1]), .oe_group_c(oe[2]), .oe_group_d(oe[3]));

   // second build: memory address and strobes on groups a to d, bus idle
   opsm_output_port #(.EXT_MEM(1'b1), .A13_ON_D1(1'b0), .BUZZ_EN(1'b1),
      .BUZZ_INV_EN(1'b1), .LCD_EN(1'b1)) dut_mem (
      .clk(clk), .sys_rst(sys_rst), .psel(1'b0), .penable(1'b0),
      .pwrite(1'b0), .paddr(14'h0), .pwdata(32'h0), .pstrb(4'h0),
      .prdata(), .pready(), .pslverr(), .slow_osc(slow_osc),
      .fast_osc(fast_osc), .ext_addr(ext_addr), .store_strobe_n(st_n),
      .load_strobe_n(ld_n), .serial_ready(ser_rdy),
      .out_group_a(mem_pins[3:0]), .out_group_b(mem_pins[7:4]),
      .out_group_c(mem_pins[11:8]), .out_group_d(mem_pins[15:12]),
      .out_group_e(), .oe_group_a(), .oe_group_b(), .oe_group_c(),
      .oe_group_d());

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [3:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= 32'(wd);
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n >= 16)
      begin
         n_mismatch++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] idx, input logic [3:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, idx, d, rd, er);
      repeat (2) @(posedge clk);
   endtask : wr

   task automatic rdc(input string what, input logic [11:0] idx, input logic [3:0] exp);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, idx, 4'h0, rd, er);
      chk(what, 32'(exp), rd);
   endtask : rdc

   // rising edges of e and d pins over a window of clock cycles
   task automatic count(input int cyc, output int r[8]);
      logic [7:0] prev;
      r = '{default: 0};
      for (int i = 0; i < cyc; i++)
      begin
         prev = pins;
         @(posedge clk);
         for (int b = 0; b < 8; b++)
            r[b] += int'(!prev[b] && pins[b]);
      end
   endtask : count

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      chk("enables at reset", 32'h0, 32'(oe));
      chk("e pins at reset", 32'h3, 32'(out_e));
      rdc("e register reset", opsm_pkg::IDX_GROUP_E, 4'hf);
      rdc("tri-state reset", opsm_pkg::IDX_HIZ, 4'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_data;
      logic [3:0]  v;
      logic [31:0] rd;
      logic        er;
      wr(opsm_pkg::IDX_HIZ, 4'hf);
      for (int i = 0; i < 4; i++)
      begin
         v = 4'h5 ^ 4'(i * 3);
         wr(opsm_pkg::IDX_GROUP_A + 12'(i), v);
         rdc("data readback", opsm_pkg::IDX_GROUP_A + 12'(i), v);
         chk("group pins", 32'(v), 32'({out_d, out_c, out_b, out_a} >> (4 * i)) & 32'hf);
      end
      wr(opsm_pkg::IDX_HIZ, 4'h5);
      chk("group enables", 32'h5, 32'(oe));
      apb(1'b0, 12'hf55, 4'h0, rd, er);
      chk("unmapped error", 32'h1, 32'(er));
      $display("test data done");
   endtask : t_data

   task automatic t_buzzer;
      int r[8];
      wr(opsm_pkg::IDX_GROUP_E, 4'h3);
      count(2048, r);
      chk("buzzer rises", 32'h1, 32'(r[7] >= 7 && r[7] <= 9 && r[6] >= 7));
      wr(opsm_pkg::IDX_GROUP_E, 4'h7);
      rdc("e2 storage", opsm_pkg::IDX_GROUP_E, 4'h7);
      count(2048, r);
      chk("inverse unaffected", 32'h1, 32'(r[6] >= 7 && r[6] <= 9));
      wr(opsm_pkg::IDX_GROUP_E, 4'hb);
      count(1024, r);
      chk("gated buzzer", 32'h0, 32'(r[7] + r[6] + 32'(out_e[3:2])));
      $display("test buzzer done");
   endtask : t_buzzer

   task automatic t_timer;
      int r[8];
      int e;
      wr(opsm_pkg::IDX_GROUP_D, 4'h8);
      wr(opsm_pkg::IDX_TIMER, 4'h8);
      count(512, r);
      chk("tick held high", 32'h1, 32'(r[3] == 0 && out_d[3]));
      wr(opsm_pkg::IDX_GROUP_D, 4'h0);
      for (int s = 0; s < 8; s++)
      begin
         wr(opsm_pkg::IDX_TIMER, 4'h8 | 4'(s));
         count(4096, r);
         e = 4096 / (32 << s);
         chk("tick rises", 32'h1, 32'(r[3] >= e - 1 && r[3] <= e + 1));
      end
      wr(opsm_pkg::IDX_TIMER, 4'h0);
      count(1024, r);
      chk("d3 plain output", 32'h0, 32'(r[3] + 32'(out_d[3])));
      $display("test timer done");
   endtask : t_timer

   task automatic t_lcd;
      int r[8];
      wr(opsm_pkg::IDX_GROUP_E, 4'hc);
      count(33000, r);
      chk("line sync rises", 32'h1, 32'(r[4] >= 63 && r[4] <= 65));
      chk("phase rises", 32'h1, 32'(r[5] >= 1 && r[5] <= 3));
      wr(opsm_pkg::IDX_GROUP_E, 4'hf);
      count(1024, r);
      chk("lcd held high", 32'h3, 32'(out_e[1:0]) + 32'(r[4] + r[5]));
      $display("test lcd done");
   endtask : t_lcd

   // memory build: pins show the sequencer's levels one clock later
   task automatic t_extmem;
      logic [15:0] exp;
      for (int i = 0; i < 32; i++)
      begin
         exp = {1'b0, ld_n, st_n, ext_addr[12:0]};
         @(posedge clk);
         chk("memory pins", 32'(exp), 32'(mem_pins));
      end
      $display("test external memory done");
   endtask : t_extmem

   // main sequence: reset for five cycles, then each scenario
   initial
   begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_data();
      t_buzzer();
      t_timer();
      t_lcd();
      t_extmem();
      report_and_stop();
   end
endmodule : tb_output_port_special_mux
